// [verilog/parmu_pkg.sv]
package parmu_pkg;
	localparam int VA_W = 16;
	localparam int PA_W = 18;
	localparam int SEL_LSB = 13;
	localparam int BLK_LSB = 6;
	localparam int BASE_W = 12;
	localparam int KEY_LSB = 1;
	localparam int DIR_BIT = 3;
	localparam int MOD_BIT = 6;
	localparam int LEN_LSB = 8;
	localparam int LEN_W = 7;
	localparam logic [1:0] KEY_NONE = 2'h0;
	localparam logic [1:0] KEY_RO = 2'h1;
	localparam logic [1:0] KEY_RW = 2'h3;
	localparam logic [1:0] MODE_KERNEL = 2'h0;
	localparam logic [1:0] MODE_USER = 2'h3;
	localparam logic [2:0] IO_TOP = 3'h7;
	localparam logic [15:0] ABORT_VECTOR = 16'h00a8;
	localparam logic [15:0] BASE_MASK = 16'h0fff;
	localparam logic [15:0] DESC_MASK = 16'h7f4e;
	localparam int XLATE_NS = 150;
	localparam int CLK_NS = 5;
	localparam int XLATE_CYC = XLATE_NS / CLK_NS;
	typedef enum logic [1:0] {
		PARMU_IDLE = 2'b00,
		PARMU_DONE = 2'b01
	} parmu_state_t;
endpackage : parmu_pkg

// [verilog/parmu_check.sv]
`timescale 1ns/10ps
// Access key and length check for one page map entry
module parmu_check (
	// Entry fields
	input wire logic [15:0] desc,
	input wire logic [6:0] block_index,
	input wire logic is_write,
	// Verdict
	output logic key_abort,
	output logic ro_abort,
	output logic len_abort
);
	logic [1:0] key;
	logic [6:0] limit;
	always_comb
	begin
		key = desc[parmu_pkg::KEY_LSB +: 2];
		limit = desc[parmu_pkg::LEN_LSB +: parmu_pkg::LEN_W];
		key_abort = (key != parmu_pkg::KEY_RO) && (key != parmu_pkg::KEY_RW);
		ro_abort = (key == parmu_pkg::KEY_RO) && is_write;
		if (desc[parmu_pkg::DIR_BIT])
			len_abort = block_index < limit;
		else
			len_abort = block_index > limit;
	end
endmodule : parmu_check

// [verilog/parmu_unit.sv]
`timescale 1ns/10ps
module parmu_unit #(
	parameter int ENTRIES = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Processor request
	input wire logic req_valid,
	input wire logic [15:0] virtual_address,
	input wire logic req_write,
	input wire logic req_vector,
	input wire logic [1:0] processor_status_mode,
	// Vector transfer: new status mode bits
	input wire logic vec_load,
	input wire logic [15:0] vec_new_status,
	// Page map register port
	input wire logic cfg_write,
	input wire logic cfg_user_set,
	input wire logic cfg_desc,
	input wire logic [2:0] cfg_index,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	// Translation enable
	input wire logic fault_status_enable,
	// Result to system bus
	output logic bus_valid,
	output logic [17:0] physical_address,
	output logic bus_write,
	output logic abort,
	output logic abort_nonres,
	output logic abort_len,
	output logic abort_ro,
	output logic [15:0] abort_vector,
	output logic [1:0] stack_mode,
	output logic [2:0] fault_page
);
	localparam int SETS = 2 * ENTRIES;
	logic [15:0] base_reg [SETS];
	logic [15:0] base_next [SETS];
	logic [15:0] desc_reg [SETS];
	logic [15:0] desc_next [SETS];
	parmu_pkg::parmu_state_t state_reg, state_next;
	logic bus_valid_reg, bus_valid_next;
	logic [17:0] pa_reg, pa_next;
	logic bus_write_reg, bus_write_next;
	logic abort_reg, abort_next;
	logic nonres_reg, nonres_next;
	logic len_reg, len_next;
	logic ro_reg, ro_next;
	logic [2:0] fpage_reg, fpage_next;
	logic [1:0] smode_reg, smode_next;
	logic en_meta_reg, en_sync_reg;
	logic [2:0] page_select_field;
	logic [12:0] page_offset_field;
	logic [6:0] block_index;
	logic [5:0] byte_in_block_offset;
	logic [3:0] entry_idx;
	logic [3:0] cfg_idx;
	logic use_user;
	logic [11:0] page_base_block;
	logic [11:0] phys_block;
	logic key_abort, ro_abort, len_abort;
	logic any_abort;

	// Entry index: set bit on top, page select below
	function automatic logic [3:0] entry_of(input logic user, input logic [2:0] page);
		entry_of = {user, page};
	endfunction : entry_of

	function automatic logic [17:0] direct_map(input logic [15:0] va);
		if (va[parmu_pkg::VA_W - 1 -: 3] == parmu_pkg::IO_TOP)
			direct_map = {2'h3, va};
		else
			direct_map = {2'h0, va};
	endfunction : direct_map

	assign page_select_field = virtual_address[parmu_pkg::SEL_LSB +: 3];
	assign page_offset_field = virtual_address[parmu_pkg::SEL_LSB - 1:0];
	assign block_index = page_offset_field[parmu_pkg::BLK_LSB +: 7];
	assign byte_in_block_offset = page_offset_field[parmu_pkg::BLK_LSB - 1:0];
	// Vectors always come from kernel space; otherwise the current mode picks the set
	assign use_user = !req_vector && (processor_status_mode == parmu_pkg::MODE_USER);
	assign entry_idx = entry_of(use_user, page_select_field);
	assign cfg_idx = entry_of(cfg_user_set, cfg_index);
	// Top four bits of the base word are ignored
	assign page_base_block = base_reg[entry_idx][parmu_pkg::BASE_W - 1:0];
	assign phys_block = page_base_block + {5'h00, block_index};

	parmu_check u_check (
		.desc(desc_reg[entry_idx]),
		.block_index(block_index),
		.is_write(req_write),
		.key_abort(key_abort),
		.ro_abort(ro_abort),
		.len_abort(len_abort)
	);

	// Modes other than kernel and user are refused, except on vector accesses
	assign any_abort = key_abort || ro_abort || len_abort || (!req_vector
		&& processor_status_mode != parmu_pkg::MODE_KERNEL
		&& processor_status_mode != parmu_pkg::MODE_USER);

	always_comb
	begin
		cfg_rdata = cfg_desc ? desc_reg[cfg_idx] : base_reg[cfg_idx];
	end

	// Page map state
	always_comb
	begin
		for (int i = 0; i < SETS; i++)
		begin
			base_next[i] = base_reg[i];
			desc_next[i] = desc_reg[i];
		end
		// A hardware write sets the modified flag; a software write in the same
		// cycle to the same entry would clear it, but the set wins
		if (cfg_write)
		begin
			if (cfg_desc)
				desc_next[cfg_idx] = cfg_wdata & parmu_pkg::DESC_MASK;
			else
			begin
				base_next[cfg_idx] = cfg_wdata & parmu_pkg::BASE_MASK;
			end
			desc_next[cfg_idx][parmu_pkg::MOD_BIT] = 1'b0;
		end
		if (req_valid && req_write && en_sync_reg && !any_abort && state_reg == parmu_pkg::PARMU_IDLE)
			desc_next[entry_idx][parmu_pkg::MOD_BIT] = 1'b1;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < SETS; i++)
			begin
				base_reg[i] <= 16'h0000;
				desc_reg[i] <= 16'h0000;
			end
		end
		else
		begin
			for (int i = 0; i < SETS; i++)
			begin
				base_reg[i] <= base_next[i];
				desc_reg[i] <= desc_next[i];
			end
		end
	end

	// Enable comes from the fault status register; treat as external level
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			en_meta_reg <= 1'b0;
			en_sync_reg <= 1'b0;
		end
		else
		begin
			en_meta_reg <= fault_status_enable;
			en_sync_reg <= en_meta_reg;
		end
	end

	// Translation pipeline: one cycle from request to bus, well inside the budget
	always_comb
	begin
		state_next = parmu_pkg::PARMU_IDLE;
		bus_valid_next = 1'b0;
		pa_next = pa_reg;
		bus_write_next = 1'b0;
		abort_next = 1'b0;
		nonres_next = nonres_reg;
		len_next = len_reg;
		ro_next = ro_reg;
		fpage_next = fpage_reg;
		smode_next = smode_reg;
		if (vec_load)
			smode_next = vec_new_status[15:14];
		case (state_reg)
			parmu_pkg::PARMU_IDLE:
			begin
				if (req_valid)
				begin
					state_next = parmu_pkg::PARMU_DONE;
					if (!en_sync_reg)
					begin
						pa_next = direct_map(virtual_address);
						bus_valid_next = 1'b1;
						bus_write_next = req_write;
					end
					else if (any_abort)
					begin
						// No bus cycle issued on abort
						abort_next = 1'b1;
						nonres_next = key_abort || (processor_status_mode != parmu_pkg::MODE_KERNEL
							&& processor_status_mode != parmu_pkg::MODE_USER);
						len_next = len_abort;
						ro_next = ro_abort;
						fpage_next = page_select_field;
					end
					else
					begin
						pa_next = {phys_block, byte_in_block_offset};
						bus_valid_next = 1'b1;
						bus_write_next = req_write;
					end
				end
			end
			parmu_pkg::PARMU_DONE:
				state_next = parmu_pkg::PARMU_IDLE;
			default:
				state_next = parmu_pkg::PARMU_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg <= parmu_pkg::PARMU_IDLE;
			bus_valid_reg <= 1'b0;
			pa_reg <= 18'h00000;
			bus_write_reg <= 1'b0;
			abort_reg <= 1'b0;
			nonres_reg <= 1'b0;
			len_reg <= 1'b0;
			ro_reg <= 1'b0;
			fpage_reg <= 3'h0;
			smode_reg <= 2'h0;
		end
		else
		begin
			state_reg <= state_next;
			bus_valid_reg <= bus_valid_next;
			pa_reg <= pa_next;
			bus_write_reg <= bus_write_next;
			abort_reg <= abort_next;
			nonres_reg <= nonres_next;
			len_reg <= len_next;
			ro_reg <= ro_next;
			fpage_reg <= fpage_next;
			smode_reg <= smode_next;
		end
	end

	assign bus_valid = bus_valid_reg;
	assign physical_address = pa_reg;
	assign bus_write = bus_write_reg;
	assign abort = abort_reg;
	assign abort_nonres = nonres_reg;
	assign abort_len = len_reg;
	assign abort_ro = ro_reg;
	assign abort_vector = parmu_pkg::ABORT_VECTOR;
	assign stack_mode = smode_reg;
	assign fault_page = fpage_reg;

	// Abort and bus cycle never together
	abort_nobus_a: assert property (@(posedge mclk) disable iff (!resetn)
		abort |-> !bus_valid) else $error("bus cycle issued on abort");
	abort_cause_a: assert property (@(posedge mclk) disable iff (!resetn)
		abort |-> (abort_nonres || abort_len || abort_ro)) else $error("abort without cause");
	req_answer_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE) |=> (bus_valid || abort))
		else $error("request not answered in one cycle");
	// The cycle after a taken request is dead, so nothing may come out of it
	done_quiet_a: assert property (@(posedge mclk) disable iff (!resetn)
		state_reg == parmu_pkg::PARMU_DONE |=> !bus_valid && !abort)
		else $error("output from a refused request");
	io_page_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && !en_sync_reg
		&& page_select_field == parmu_pkg::IO_TOP) |=> physical_address[17:16] == 2'h3)
		else $error("top page not forced high");
	low_page_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && !en_sync_reg
		&& page_select_field != parmu_pkg::IO_TOP) |=> physical_address[17:16] == 2'h0)
		else $error("low page bits not clear");
	pass_low_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && !en_sync_reg)
		|=> bus_valid && physical_address[15:0] == $past(virtual_address))
		else $error("address relocated while translation off");
	offset_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
		bus_valid |-> physical_address[5:0] == $past(virtual_address[5:0]))
		else $error("byte offset altered");
	write_class_a: assert property (@(posedge mclk) disable iff (!resetn)
		bus_valid |-> bus_write == $past(req_write))
		else $error("write class lost on the bus");
	key_none_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && en_sync_reg
		&& !desc_reg[entry_idx][parmu_pkg::KEY_LSB]) |=> abort && abort_nonres)
		else $error("access to non-resident page not aborted");
	ro_write_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && en_sync_reg && req_write
		&& desc_reg[entry_idx][parmu_pkg::KEY_LSB +: 2] == parmu_pkg::KEY_RO) |=> abort && abort_ro)
		else $error("write to read-only page not aborted");
	mode_bad_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && en_sync_reg && !req_vector
		&& processor_status_mode != parmu_pkg::MODE_KERNEL
		&& processor_status_mode != parmu_pkg::MODE_USER) |=> abort && abort_nonres)
		else $error("illegal mode not aborted");
	len_up_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && en_sync_reg
		&& !desc_reg[entry_idx][parmu_pkg::DIR_BIT]
		&& block_index > desc_reg[entry_idx][parmu_pkg::LEN_LSB +: parmu_pkg::LEN_W])
		|=> abort && abort_len) else $error("block beyond upward page not aborted");
	len_down_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && en_sync_reg
		&& desc_reg[entry_idx][parmu_pkg::DIR_BIT]
		&& block_index < desc_reg[entry_idx][parmu_pkg::LEN_LSB +: parmu_pkg::LEN_W])
		|=> abort && abort_len) else $error("block below downward page not aborted");
	mod_set_a: assert property (@(posedge mclk) disable iff (!resetn)
		(req_valid && state_reg == parmu_pkg::PARMU_IDLE && en_sync_reg && req_write
		&& !any_abort) |=> desc_reg[$past(entry_idx)][parmu_pkg::MOD_BIT])
		else $error("modified flag not set");
	mod_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
		(cfg_write && !(req_valid && req_write)) |=> !desc_reg[$past(cfg_idx)][parmu_pkg::MOD_BIT])
		else $error("modified flag not cleared");
	stack_pick_a: assert property (@(posedge mclk) disable iff (!resetn)
		vec_load |=> stack_mode == $past(vec_new_status[15:14]))
		else $error("stack mode not taken from new status");
endmodule : parmu_unit

// [sim/parmu_core_model.sv]
`timescale 1ns/10ps
// Processor core side: one request at a time, held for its take edge only
module parmu_core_model (
	// Clock
	input wire logic mclk,
	// Request
	output logic req_valid,
	output logic [15:0] virtual_address,
	output logic req_write,
	output logic req_vector,
	output logic [1:0] processor_status_mode,
	// Answer
	input wire logic bus_valid,
	input wire logic abort
);
	initial
	begin
		req_valid = 1'b0;
		virtual_address = 16'h0000;
		req_write = 1'b0;
		req_vector = 1'b0;
		processor_status_mode = 2'h0;
	end

	// Address is scrambled once released so a stale value cannot pass for a live one
	task automatic access(input logic [15:0] va, input logic wr, input logic vec,
		input logic [1:0] mode, output logic got_bus, output logic got_abort);
		got_bus = 1'b0;
		got_abort = 1'b0;
		@(posedge mclk);
		req_valid <= 1'b1;
		virtual_address <= va;
		req_write <= wr;
		req_vector <= vec;
		processor_status_mode <= mode;
		@(posedge mclk);
		req_valid <= 1'b0;
		virtual_address <= ~va;
		for (int i = 0; i < 3; i++)
		begin
			#1;
			got_bus = (bus_valid === 1'b1);
			got_abort = (abort === 1'b1);
			if (got_bus || got_abort)
				break;
			@(posedge mclk);
		end
	endtask : access
endmodule : parmu_core_model

// [sim/parmu_unit_bench.sv]
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
	$display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module parmu_unit_bench;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic cfg_write = 1'b0, cfg_user_set = 1'b0, cfg_desc = 1'b0;
	logic [2:0] cfg_index = 3'h0;
	logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, vec_new_status = 16'h0000, abort_vector;
	logic fault_status_enable = 1'b0, vec_load = 1'b0;
	logic req_valid, req_write, req_vector, bus_valid, bus_write, abort;
	logic abort_nonres, abort_len, abort_ro;
	logic [15:0] virtual_address;
	logic [1:0] processor_status_mode, stack_mode;
	logic [17:0] physical_address;
	logic [2:0] fault_page;
	int miscompares = 0;
	int check_count = 0;

	always #2.5 mclk = ~mclk;

	parmu_unit i_dut (.mclk(mclk), .resetn(resetn), .req_valid(req_valid),
		.virtual_address(virtual_address), .req_write(req_write), .req_vector(req_vector),
		.processor_status_mode(processor_status_mode), .vec_load(vec_load),
		.vec_new_status(vec_new_status), .cfg_write(cfg_write), .cfg_user_set(cfg_user_set),
		.cfg_desc(cfg_desc), .cfg_index(cfg_index), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .fault_status_enable(fault_status_enable),
		.bus_valid(bus_valid), .physical_address(physical_address), .bus_write(bus_write),
		.abort(abort), .abort_nonres(abort_nonres), .abort_len(abort_len),
		.abort_ro(abort_ro), .abort_vector(abort_vector), .stack_mode(stack_mode),
		.fault_page(fault_page));

	parmu_core_model i_core (.mclk(mclk), .req_valid(req_valid),
		.virtual_address(virtual_address), .req_write(req_write), .req_vector(req_vector),
		.processor_status_mode(processor_status_mode), .bus_valid(bus_valid), .abort(abort));

	task automatic cfg(input logic us, input logic d, input logic [2:0] i, input logic [15:0] v);
		@(posedge mclk);
		cfg_write <= 1'b1;
		cfg_user_set <= us;
		cfg_desc <= d;
		cfg_index <= i;
		cfg_wdata <= v;
		@(posedge mclk);
		cfg_write <= 1'b0;
	endtask : cfg

	task automatic rd(input logic us, input logic d, input logic [2:0] i, input logic [15:0] e);
		@(posedge mclk);
		cfg_user_set <= us;
		cfg_desc <= d;
		cfg_index <= i;
		#1;
		`CHK(cfg_rdata, e)
	endtask : rd

	// Bus and abort are exclusive; the address is only judged when the bus fires
	task automatic acc(input logic [15:0] va, input logic wr, input logic vec,
		input logic [1:0] m, input logic eb, input logic [17:0] pa);
		logic gb;
		logic ga;
		i_core.access(va, wr, vec, m, gb, ga);
		`CHK({gb, ga}, {eb, ~eb})
		if (eb)
			`CHK({bus_write, physical_address}, {wr, pa})
	endtask : acc

	task automatic t_regs;
		cfg(1'b0, 1'b0, 3'h2, 16'hffff);
		rd(1'b0, 1'b0, 3'h2, 16'h0fff);
		cfg(1'b0, 1'b1, 3'h2, 16'hffff);
		rd(1'b0, 1'b1, 3'h2, 16'h7f0e);
	endtask : t_regs

	task automatic t_pass;
		acc(16'hf0a4, 1'b0, 1'b0, 2'h3, 1'b1, 18'h3f0a4);
		acc(16'h1234, 1'b1, 1'b0, 2'h0, 1'b1, 18'h01234);
	endtask : t_pass

	task automatic t_map;
		cfg(1'b0, 1'b0, 3'h2, 16'hf800);
		cfg(1'b0, 1'b1, 3'h2, 16'h7f06);
		cfg(1'b1, 1'b0, 3'h2, 16'h0400);
		cfg(1'b1, 1'b1, 3'h2, 16'h7f06);
		@(posedge mclk);
		fault_status_enable <= 1'b1;
		repeat (3) @(posedge mclk);
		acc(16'h4149, 1'b0, 1'b0, 2'h0, 1'b1, 18'h20149);
		acc(16'h4149, 1'b0, 1'b0, 2'h3, 1'b1, 18'h10149);
		acc(16'h4149, 1'b0, 1'b1, 2'h3, 1'b1, 18'h20149);
		acc(16'h4149, 1'b1, 1'b0, 2'h0, 1'b1, 18'h20149);
		rd(1'b0, 1'b1, 3'h2, 16'h7f46);
		cfg(1'b0, 1'b0, 3'h2, 16'h0800);
		rd(1'b0, 1'b1, 3'h2, 16'h7f06);
	endtask : t_map

	task automatic t_keys;
		logic ok;
		for (int k = 0; k < 4; k++)
			for (int w = 0; w < 2; w++)
			begin
				cfg(1'b0, 1'b1, 3'h3, 16'h7f00 | 16'(k << 1));
				ok = (k == 3) || (k == 1 && w == 0);
				acc(16'h6000, 1'(w), 1'b0, 2'h0, ok, 18'h00000);
				if (!ok)
					`CHK({abort_ro, abort_nonres, fault_page}, {1'(k == 1), 1'(k != 1), 3'h3})
			end
	endtask : t_keys

	task automatic t_len;
		cfg(1'b0, 1'b1, 3'h4, 16'h0306);
		acc(16'h8100, 1'b0, 1'b0, 2'h0, 1'b0, 18'h00000);
		`CHK(abort_len, 1'b1)
		acc(16'h80c5, 1'b0, 1'b0, 2'h0, 1'b1, 18'h000c5);
		cfg(1'b0, 1'b1, 3'h4, 16'h030e);
		acc(16'h8080, 1'b0, 1'b0, 2'h0, 1'b0, 18'h00000);
		acc(16'h80c0, 1'b0, 1'b0, 2'h0, 1'b1, 18'h000c0);
		acc(16'h80c0, 1'b0, 1'b0, 2'h1, 1'b0, 18'h00000);
		`CHK({abort_nonres, abort_len}, 2'h2)
	endtask : t_len

	task automatic t_vec;
		`CHK(abort_vector, 16'h00a8)
		@(posedge mclk);
		vec_load <= 1'b1;
		vec_new_status <= 16'hc000;
		@(posedge mclk);
		vec_load <= 1'b0;
		#1;
		`CHK(stack_mode, 2'h3)
	endtask : t_vec

	task automatic results;
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	initial
	begin
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		t_regs();
		t_pass();
		t_map();
		t_keys();
		t_len();
		t_vec();
		results();
	end

	// Whole run needs under a hundred cycles
	initial
	begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		results();
	end
endmodule : parmu_unit_bench
